// >>> pkg/fault_monitor_pkg.sv
// shared constants for the servo motion fault monitor
package fault_monitor_pkg;
   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_CONTROL       = 8'h00;
   localparam logic [7:0] OFS_POS_LIMIT_A   = 8'h04;
   localparam logic [7:0] OFS_POS_LIMIT_B   = 8'h08;
   localparam logic [7:0] OFS_CL_THRESHOLD  = 8'h0c;
   localparam logic [7:0] OFS_CL_CLEAR_CYC  = 8'h10;
   localparam logic [7:0] OFS_OVL_PERCENT   = 8'h14;
   localparam logic [7:0] OFS_OVL_TIME      = 8'h18;
   localparam logic [7:0] OFS_INDEX_RES     = 8'h1c;
   localparam logic [7:0] OFS_INDEX_TOL     = 8'h20;
   localparam logic [7:0] OFS_FAULT_STATUS  = 8'h24;
   localparam logic [7:0] OFS_FAULT_CODE    = 8'h28;
   localparam logic [7:0] OFS_CL_ERROR      = 8'h2c;
   localparam logic [7:0] OFS_MOTION_STATUS = 8'h30;

   // ----------------------------------------
   // control register fields
   // ----------------------------------------
   localparam int CTL_SW_LIMIT_EN = 0;  // limit_enable_select, software limits
   localparam int CTL_HW_LIMIT_EN = 1;  // limit_enable_select, hardware limits
   localparam int CTL_FULL_CLOSED = 2;
   localparam int CTL_SEC_POL     = 3;  // second_encoder_polarity
   localparam int CTL_PROHIB_FWD  = 4;  // direction_prohibit_select bit 0
   localparam int CTL_PROHIB_REV  = 5;  // direction_prohibit_select bit 1
   localparam int CTL_WIDTH       = 6;

   // ----------------------------------------
   // fault bit positions and codes
   // ----------------------------------------
   localparam int FLT_NO_HOME  = 0;
   localparam int FLT_OVERLOAD = 1;
   localparam int FLT_SW_LIMIT = 2;
   localparam int FLT_HW_LIMIT = 3;
   localparam int FLT_PLAN     = 4;
   localparam int FLT_CL_ERROR = 5;
   localparam int FLT_DIR      = 6;
   localparam int FLT_INDEX    = 7;
   localparam int FLT_COUNT    = 8;

   localparam logic [15:0] FAULT_CODES [FLT_COUNT] = '{
      16'h00cd, 16'h00ce, 16'h00cf, 16'h00d0,
      16'h00d1, 16'h00d5, 16'h00d6, 16'h00d8};
   localparam logic [15:0] CODE_NONE = 16'h0000;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [CTL_WIDTH-1:0] CONTROL_RST = 6'h00;
   localparam logic [31:0] POS_LIMIT_A_RST  = 32'h8000_0000;
   localparam logic [31:0] POS_LIMIT_B_RST  = 32'h7fff_ffff;
   localparam logic [31:0] CL_THRESHOLD_RST = 32'h0000_2710;
   localparam logic [31:0] CL_CLEAR_RST     = 32'h0000_0000;
   localparam logic [15:0] OVL_PERCENT_RST  = 16'h0064;
   localparam logic [31:0] OVL_TIME_RST     = 32'h0004_c4b4;
   localparam logic [31:0] INDEX_RES_RST    = 32'h0002_0000;
   localparam logic [31:0] INDEX_TOL_RST    = 32'h0000_0010;
   localparam logic [31:0] WORD_ZERO        = 32'h0000_0000;
endpackage : fault_monitor_pkg

// >>> src/persist_timer.sv
// counts how long a condition holds without a break
`timescale 1ns/100ps
module persist_timer #(
   parameter int WIDTH = 32
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             cond_i,
   input  wire logic [WIDTH-1:0] limit_i,
   output logic                  fire_o
);
   typedef struct packed {
      logic [WIDTH-1:0] cnt;
      logic             fire;
   } state_s;

   state_s st_r;
   state_s st_nxt;

   // count while the condition lasts, restart on any gap
   always_comb begin
      st_nxt = st_r;
      if (!cond_i) begin
         st_nxt.cnt = '0;
      end else if (st_r.cnt != '1) begin
         st_nxt.cnt = st_r.cnt + WIDTH'(1);
      end
      // a zero limit still needs one cycle of the condition
      st_nxt.fire = cond_i && (st_nxt.cnt >= limit_i) && (st_nxt.cnt != '0);
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign fire_o = st_r.fire;
endmodule : persist_timer

// >>> src/index_stability_check.sv
// compares encoder travel between successive index pulses to the resolution
`timescale 1ns/100ps
module index_stability_check #(
   parameter int WIDTH = 32
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             index_i,
   input  wire logic [WIDTH-1:0] enc_pos_i,
   input  wire logic [WIDTH-1:0] resolution_i,
   input  wire logic [WIDTH-1:0] tolerance_i,
   output logic                  unstable_o
);
   typedef struct packed {
      logic             have_first;
      logic [WIDTH-1:0] last_pos;
      logic             unstable;
   } state_s;

   state_s           st_r;
   state_s           st_nxt;
   logic [WIDTH-1:0] travel;
   logic [WIDTH-1:0] dev;

   // travel is taken as a magnitude so reverse rotation checks the same way
   always_comb begin
      st_nxt          = st_r;
      st_nxt.unstable = 1'b0;
      travel = enc_pos_i - st_r.last_pos;
      if (travel[WIDTH-1]) begin
         travel = WIDTH'(0) - travel;
      end
      dev = travel - resolution_i;
      if (dev[WIDTH-1]) begin
         dev = WIDTH'(0) - dev;
      end
      if (index_i) begin
         st_nxt.have_first = 1'b1;
         st_nxt.last_pos   = enc_pos_i;
         st_nxt.unstable   = st_r.have_first && (dev > tolerance_i); // [R16] [R18]
      end
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign unstable_o = st_r.unstable;
endmodule : index_stability_check

// >>> src/servo_motion_fault_monitor.sv
// servo drive motion fault monitor with classic wishbone register slave
//
// Function
// R1: absolute multi-segment move before homing completed raises no-homing fault.
// R2: current above rated threshold continuously for set time raises overload fault.
// R3: software limit check runs only when limit_enable_select enables it.
// R4: position below lower limit with negative speed raises software limit fault.
// R5: position above upper limit with positive speed raises software limit fault.
// R6: lower and upper limits come from position_limit_value_a and _b.
// R7: hardware limit check runs only when limit_enable_select enables it.
// R8: reverse switch active with negative speed raises hardware limit fault.
// R9: forward switch active with positive speed raises hardware limit fault.
// R10: failed fourth-order profile planning raises planning fault.
// R11: full-closed-loop: large second versus converted motor position error faults.
// R12: closed-loop error limit comes from closed_loop_error_threshold.
// R13: accumulated closed-loop error clears every closed_loop_error_clear_cycles cycles.
// R14: second encoder count polarity follows second_encoder_polarity in full-closed mode.
// R15: rotation command in a direction_prohibit_select forbidden direction raises fault.
// R16: index-to-index encoder travel far from resolution raises unstable index fault.
// R17: faults stay latched with readable code until software clears them.
// R18: index stability tolerance is a writable register with a default.
`timescale 1ns/100ps
module servo_motion_fault_monitor #(
   parameter int PW = 32,
   parameter int CW = 16
) (
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   // wishbone classic slave
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire logic [7:0]    wb_adr_i,
   input  wire logic [3:0]    wb_sel_i,
   input  wire logic [31:0]   wb_dat_i,
   output logic      [31:0]   wb_dat_o,
   output logic               wb_ack_o,
   // motion command side
   input  wire logic          abs_move_trigger_i,
   input  wire logic          homing_done_i,
   input  wire logic          plan_fail_i,
   input  wire logic          rot_cmd_valid_i,
   input  wire logic          rot_cmd_fwd_i,
   input  wire logic [PW-1:0] speed_i,
   input  wire logic [PW-1:0] user_pos_i,
   // motor side
   input  wire logic [CW-1:0] current_pct_i,
   input  wire logic          fwd_limit_i,
   input  wire logic          rev_limit_i,
   input  wire logic [PW-1:0] motor_pos_conv_i,
   input  wire logic [PW-1:0] second_pos_i,
   input  wire logic          index_i,
   input  wire logic [PW-1:0] enc_pos_i,
   // fault report
   output logic               fault_o,
   output logic [15:0]        fault_code_o,
   output logic               homed_o
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef logic [fault_monitor_pkg::CTL_WIDTH-1:0] ctl_t;
   typedef logic [fault_monitor_pkg::FLT_COUNT-1:0] flt_t;

   typedef struct packed {
      logic          ack;
      logic [31:0]   rdata;
      ctl_t          control;
      logic [PW-1:0] pos_limit_a;
      logic [PW-1:0] pos_limit_b;
      logic [PW-1:0] cl_threshold;
      logic [31:0]   cl_clear_cycles;
      logic [CW-1:0] ovl_percent;
      logic [31:0]   ovl_time;
      logic [PW-1:0] index_res;
      logic [PW-1:0] index_tol;
      logic          homed;
      logic [31:0]   clear_cnt;
      logic [PW-1:0] motor_base;
      logic [PW-1:0] second_base;
      logic [PW-1:0] cl_error;
      flt_t          faults;
      logic [15:0]   code;
      logic          fault;
   } state_s;

   state_s        st_r;
   state_s        st_nxt;
   logic          overload_fire;
   logic          index_unstable;
   flt_t          fault_set;
   flt_t          fault_clr;
   logic [PW-1:0] second_signed;
   logic [PW-1:0] cl_err_now;
   logic [PW-1:0] cl_err_mag;
   logic          speed_neg;
   logic          speed_pos;
   logic          req;
   logic          wr_take;
   logic [31:0]   rd_word;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // merge write data into a register under the byte enables
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return res;
   endfunction : merge

   // code of the lowest numbered latched fault
   function automatic logic [15:0] first_code(
      input logic [fault_monitor_pkg::FLT_COUNT-1:0] f);
      logic [15:0] c;
      c = fault_monitor_pkg::CODE_NONE;
      for (int i = fault_monitor_pkg::FLT_COUNT - 1; i >= 0; i--) begin
         if (f[i]) begin
            c = fault_monitor_pkg::FAULT_CODES[i];
         end
      end
      return c;
   endfunction : first_code

   // ----------------------------------------
   // sub blocks
   // ----------------------------------------
   // current over threshold without a break for the programmed time
   persist_timer #(
      .WIDTH (32)
   ) u_overload (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .cond_i  (current_pct_i > st_r.ovl_percent),      // [R2]
      .limit_i (st_r.ovl_time),
      .fire_o  (overload_fire)
   );

   // index pulse spacing check
   index_stability_check #(
      .WIDTH (PW)
   ) u_index (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .index_i      (index_i),
      .enc_pos_i    (enc_pos_i),
      .resolution_i (st_r.index_res),
      .tolerance_i  (st_r.index_tol),                    // [R18]
      .unstable_o   (index_unstable)
   );

   // ----------------------------------------
   // fault detection
   // ----------------------------------------
   // speed sign and second encoder polarity
   always_comb begin
      speed_neg = speed_i[PW-1];
      speed_pos = !speed_i[PW-1] && (speed_i != '0);
      if (st_r.control[fault_monitor_pkg::CTL_SEC_POL]) begin
         second_signed = PW'(0) - second_pos_i;                    // [R14]
      end else begin
         second_signed = second_pos_i;
      end
      cl_err_now = (second_signed - st_r.second_base)
                 - (motor_pos_conv_i - st_r.motor_base);
      if (st_r.cl_error[PW-1]) begin
         cl_err_mag = PW'(0) - st_r.cl_error;
      end else begin
         cl_err_mag = st_r.cl_error;
      end
   end

   // raw fault events of this cycle
   always_comb begin
      fault_set = '0;
      fault_set[fault_monitor_pkg::FLT_NO_HOME] =
         abs_move_trigger_i && !st_r.homed;                        // [R1]
      fault_set[fault_monitor_pkg::FLT_OVERLOAD] = overload_fire;  // [R2]
      fault_set[fault_monitor_pkg::FLT_SW_LIMIT] =
         st_r.control[fault_monitor_pkg::CTL_SW_LIMIT_EN] &&       // [R3]
         (($signed(user_pos_i) < $signed(st_r.pos_limit_a) && speed_neg) || // [R4] [R6]
          ($signed(user_pos_i) > $signed(st_r.pos_limit_b) && speed_pos));  // [R5] [R6]
      fault_set[fault_monitor_pkg::FLT_HW_LIMIT] =
         st_r.control[fault_monitor_pkg::CTL_HW_LIMIT_EN] &&       // [R7]
         ((rev_limit_i && speed_neg) ||                            // [R8]
          (fwd_limit_i && speed_pos));                             // [R9]
      fault_set[fault_monitor_pkg::FLT_PLAN] = plan_fail_i;        // [R10]
      fault_set[fault_monitor_pkg::FLT_CL_ERROR] =
         st_r.control[fault_monitor_pkg::CTL_FULL_CLOSED] &&
         (cl_err_mag > st_r.cl_threshold);                         // [R11] [R12]
      fault_set[fault_monitor_pkg::FLT_DIR] = rot_cmd_valid_i &&
         ((rot_cmd_fwd_i && st_r.control[fault_monitor_pkg::CTL_PROHIB_FWD]) ||
          (!rot_cmd_fwd_i && st_r.control[fault_monitor_pkg::CTL_PROHIB_REV])); // [R15]
      fault_set[fault_monitor_pkg::FLT_INDEX] = index_unstable;    // [R16]
   end

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   assign req     = wb_cyc_i && wb_stb_i;
   assign wr_take = req && wb_we_i && st_r.ack;

   // read multiplexer, unmapped offsets read zero
   always_comb begin
      rd_word = fault_monitor_pkg::WORD_ZERO;
      case (wb_adr_i)
         fault_monitor_pkg::OFS_CONTROL:      rd_word = 32'(st_r.control);
         fault_monitor_pkg::OFS_POS_LIMIT_A:  rd_word = 32'(st_r.pos_limit_a);
         fault_monitor_pkg::OFS_POS_LIMIT_B:  rd_word = 32'(st_r.pos_limit_b);
         fault_monitor_pkg::OFS_CL_THRESHOLD: rd_word = 32'(st_r.cl_threshold);
         fault_monitor_pkg::OFS_CL_CLEAR_CYC: rd_word = st_r.cl_clear_cycles;
         fault_monitor_pkg::OFS_OVL_PERCENT:  rd_word = 32'(st_r.ovl_percent);
         fault_monitor_pkg::OFS_OVL_TIME:     rd_word = st_r.ovl_time;
         fault_monitor_pkg::OFS_INDEX_RES:    rd_word = 32'(st_r.index_res);
         fault_monitor_pkg::OFS_INDEX_TOL:    rd_word = 32'(st_r.index_tol);
         fault_monitor_pkg::OFS_FAULT_STATUS: rd_word = 32'(st_r.faults);
         fault_monitor_pkg::OFS_FAULT_CODE:   rd_word = 32'(st_r.code);
         fault_monitor_pkg::OFS_CL_ERROR:     rd_word = 32'(st_r.cl_error);
         fault_monitor_pkg::OFS_MOTION_STATUS: rd_word = 32'(st_r.homed);
         default:                             rd_word = fault_monitor_pkg::WORD_ZERO;
      endcase
   end

   // write-one-to-clear of latched faults
   always_comb begin
      fault_clr = '0;
      if (wr_take && wb_adr_i == fault_monitor_pkg::OFS_FAULT_STATUS) begin
         fault_clr = flt_t'(merge(fault_monitor_pkg::WORD_ZERO, wb_dat_i, wb_sel_i));
      end
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;
      // single wait state answer, ack drops the cycle after
      st_nxt.ack   = req && !st_r.ack;
      st_nxt.rdata = (req && !st_r.ack) ? rd_word : st_r.rdata;

      // writes land on the edge where ack is seen
      if (wr_take) begin
         case (wb_adr_i)
            fault_monitor_pkg::OFS_CONTROL: st_nxt.control =
               ctl_t'(merge(32'(st_r.control), wb_dat_i, wb_sel_i));
            fault_monitor_pkg::OFS_POS_LIMIT_A: st_nxt.pos_limit_a =
               PW'(merge(32'(st_r.pos_limit_a), wb_dat_i, wb_sel_i));   // [R6]
            fault_monitor_pkg::OFS_POS_LIMIT_B: st_nxt.pos_limit_b =
               PW'(merge(32'(st_r.pos_limit_b), wb_dat_i, wb_sel_i));   // [R6]
            fault_monitor_pkg::OFS_CL_THRESHOLD: st_nxt.cl_threshold =
               PW'(merge(32'(st_r.cl_threshold), wb_dat_i, wb_sel_i));  // [R12]
            fault_monitor_pkg::OFS_CL_CLEAR_CYC: st_nxt.cl_clear_cycles =
               merge(st_r.cl_clear_cycles, wb_dat_i, wb_sel_i);         // [R13]
            fault_monitor_pkg::OFS_OVL_PERCENT: st_nxt.ovl_percent =
               CW'(merge(32'(st_r.ovl_percent), wb_dat_i, wb_sel_i));
            fault_monitor_pkg::OFS_OVL_TIME: st_nxt.ovl_time =
               merge(st_r.ovl_time, wb_dat_i, wb_sel_i);
            fault_monitor_pkg::OFS_INDEX_RES: st_nxt.index_res =
               PW'(merge(32'(st_r.index_res), wb_dat_i, wb_sel_i));
            fault_monitor_pkg::OFS_INDEX_TOL: st_nxt.index_tol =
               PW'(merge(32'(st_r.index_tol), wb_dat_i, wb_sel_i));     // [R18]
            default: ;
         endcase
      end

      // homing completion is remembered until reset
      if (homing_done_i) begin
         st_nxt.homed = 1'b1;
      end

      // closed-loop error accumulates from the last clear point
      st_nxt.cl_error = cl_err_now;
      if (st_r.cl_clear_cycles != fault_monitor_pkg::WORD_ZERO &&
          st_r.clear_cnt + 32'h1 >= st_r.cl_clear_cycles) begin      // [R13]
         st_nxt.clear_cnt   = fault_monitor_pkg::WORD_ZERO;
         st_nxt.motor_base  = motor_pos_conv_i;
         st_nxt.second_base = second_signed;
         st_nxt.cl_error    = '0;
      end else begin
         st_nxt.clear_cnt = st_r.clear_cnt + 32'h1;
      end
      if (!st_r.control[fault_monitor_pkg::CTL_FULL_CLOSED]) begin
         // outside full-closed mode track the feedback so entry starts clean
         st_nxt.motor_base  = motor_pos_conv_i;
         st_nxt.second_base = second_signed;
         st_nxt.cl_error    = '0;
      end

      // latched faults, a new event wins over a clear in the same cycle
      st_nxt.faults = (st_r.faults & ~fault_clr) | fault_set;        // [R17]
      st_nxt.code   = first_code(st_nxt.faults);                     // [R17]
      st_nxt.fault  = |st_nxt.faults;
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r                 <= '0;
         st_r.control         <= fault_monitor_pkg::CONTROL_RST;
         st_r.pos_limit_a     <= PW'(fault_monitor_pkg::POS_LIMIT_A_RST);
         st_r.pos_limit_b     <= PW'(fault_monitor_pkg::POS_LIMIT_B_RST);
         st_r.cl_threshold    <= PW'(fault_monitor_pkg::CL_THRESHOLD_RST);
         st_r.cl_clear_cycles <= fault_monitor_pkg::CL_CLEAR_RST;
         st_r.ovl_percent     <= CW'(fault_monitor_pkg::OVL_PERCENT_RST);
         st_r.ovl_time        <= fault_monitor_pkg::OVL_TIME_RST;
         st_r.index_res       <= PW'(fault_monitor_pkg::INDEX_RES_RST);
         st_r.index_tol       <= PW'(fault_monitor_pkg::INDEX_TOL_RST);
         st_r.code            <= fault_monitor_pkg::CODE_NONE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign wb_ack_o     = st_r.ack;
   assign wb_dat_o     = st_r.rdata;
   assign fault_o      = st_r.fault;
   assign fault_code_o = st_r.code;
   assign homed_o      = st_r.homed;
endmodule : servo_motion_fault_monitor

// >>> bench/servo_motion_fault_monitor_monitor.sv
// port assertions for the servo motion fault monitor
`timescale 1ns/100ps
module servo_motion_fault_monitor_monitor (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        abs_move_trigger_i,
   input wire logic        homing_done_i,
   input wire logic        plan_fail_i,
   input wire logic        fault_o,
   input wire logic [15:0] fault_code_o,
   input wire logic        homed_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic clr;
   // write-one-to-clear of the fault status word
   assign clr = wb_ack_o && wb_we_i && (wb_adr_i == 8'h24);
   sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
   AST_ACK_ONE: assert property (s_take |=> s_ans)
      else $error("ack timing");
   AST_DAT_HOLD: assert property (!(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o))
      else $error("read data moved");
   AST_NO_HOME: assert property (abs_move_trigger_i && !homed_o && !homing_done_i |=>
      fault_o && fault_code_o == 16'h00cd) else $error("no-homing fault missing");
   AST_HOMED: assert property (homing_done_i |=> homed_o)
      else $error("homed flag not set");
   AST_HOMED_KEEP: assert property (homed_o |=> homed_o)
      else $error("homed flag dropped");
   AST_PLAN: assert property (plan_fail_i |=> fault_o)
      else $error("planning fault missing");
   AST_STICKY: assert property (fault_o && !clr |=> fault_o)
      else $error("fault dropped");
   AST_CODE: assert property (fault_o == (fault_code_o != 16'h0000))
      else $error("code mismatch");
endmodule : servo_motion_fault_monitor_monitor
bind servo_motion_fault_monitor servo_motion_fault_monitor_monitor mon_u (.clk_i(clk_i),
   .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .abs_move_trigger_i(abs_move_trigger_i), .homing_done_i(homing_done_i),
   .plan_fail_i(plan_fail_i), .fault_o(fault_o), .fault_code_o(fault_code_o),
   .homed_o(homed_o));

// >>> bench/motor_side_model.sv
// motor with encoder, index mark and second encoder on the load
`timescale 1ns/100ps
module motor_side_model (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [31:0] step_i,
   input  wire logic [31:0] res_i,
   input  wire logic [31:0] slip_i,
   input  wire logic        miss_i,
   output logic [31:0]      enc_pos_o,
   output logic [31:0]      motor_pos_conv_o,
   output logic [31:0]      second_pos_o,
   output logic             index_o
);
   logic [31:0] ang;
   // shaft turns by step each cycle; index once a turn; miss drops counts
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ang       <= '0;
         enc_pos_o <= '0;
         index_o   <= 1'b0;
      end else begin
         enc_pos_o <= enc_pos_o + (miss_i ? 32'h0 : step_i);
         index_o   <= (ang + step_i >= res_i);
         ang       <= (ang + step_i >= res_i) ? ang + step_i - res_i : ang + step_i;
      end
   end
   assign motor_pos_conv_o = enc_pos_o;
   assign second_pos_o     = enc_pos_o + slip_i; // load slips against motor
endmodule : motor_side_model

// >>> bench/servo_motion_fault_monitor_tb.sv
// self-checking bench for the servo motion fault monitor
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_mismatch++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module servo_motion_fault_monitor_tb;
   localparam logic [31:0] NEG = 32'hffff_fffb;
   logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, idx;
   logic [4:0] pl = '0; // pulsed inputs: move, homed, plan fail, rotate, miss
   logic rot_cmd_fwd_i = 0, fwd_limit_i = 0, rev_limit_i = 0, fault_o, homed_o;
   logic [7:0]  wb_adr_i = 0;
   logic [15:0] current_pct_i = 0, fault_code_o;
   logic [31:0] wb_dat_i = 0, speed_i = 0, user_pos_i = 0, step = 0, slip = 0;
   logic [31:0] wb_dat_o, enc, mpos, spos, q;
   int n_mismatch = 0, samples_checked = 0;
   always #10 clk_i = ~clk_i;
   servo_motion_fault_monitor dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .abs_move_trigger_i(pl[0]),
      .homing_done_i(pl[1]), .plan_fail_i(pl[2]), .rot_cmd_valid_i(pl[3]), .rot_cmd_fwd_i,
      .speed_i, .user_pos_i,
      .current_pct_i, .fwd_limit_i, .rev_limit_i, .motor_pos_conv_i(mpos),
      .second_pos_i(spos), .index_i(idx), .enc_pos_i(enc), .fault_o, .fault_code_o, .homed_o);
   motor_side_model mdl_u (.clk_i, .rst_i, .step_i(step), .res_i(32'h0000_0100),
      .slip_i(slip), .miss_i(pl[4]), .enc_pos_o(enc), .motor_pos_conv_o(mpos),
      .second_pos_o(spos), .index_o(idx));
   // one classic cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
      n = 0;
      do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 50);
      if (n == 50) begin n_mismatch++; final_report(); end
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
   endtask : wb
   task automatic pulse(input int k);
      @(posedge clk_i) pl[k] <= 1'b1;
      @(posedge clk_i) pl[k] <= 1'b0;
   endtask : pulse
   // read the latched code, then clear every fault
   task automatic flt(input logic [15:0] c);
      repeat (4) @(posedge clk_i);
      wb(1'b0, 8'h28, 32'h0);
      `CHK(q[15:0], c)
      wb(1'b1, 8'h24, 32'h0000_00ff);
      repeat (2) @(posedge clk_i);
      `CHK(fault_o, 1'b0)
   endtask : flt
   task automatic cond(input logic [31:0] sp, input logic [15:0] c);
      speed_i <= sp;
      repeat (3) @(posedge clk_i);
      speed_i <= 32'h0;
      flt(c);
   endtask : cond
   task automatic t_regs;
      wb(1'b0, 8'h0c, 32'h0); `CHK(q, 32'h0000_2710)
      wb(1'b0, 8'h20, 32'h0); `CHK(q, 32'h0000_0010)
      wb(1'b1, 8'h40, 32'hffff_ffff); wb(1'b0, 8'h40, 32'h0); `CHK(q, 32'h0)
      wb(1'b1, 8'h04, 32'h0000_0064); wb(1'b0, 8'h04, 32'h0); `CHK(q, 32'h64)
      wb(1'b1, 8'h1c, 32'h0000_0100);
   endtask : t_regs
   task automatic t_cmd;
      pulse(0); flt(16'h00cd);
      pulse(1); pulse(0); flt(16'h0000);
      pulse(2); flt(16'h00d1);
      wb(1'b1, 8'h00, 32'h10); pulse(3); flt(16'h0000);
      rot_cmd_fwd_i <= 1'b1; pulse(3); flt(16'h00d6);
      wb(1'b1, 8'h00, 32'h20); pulse(3); flt(16'h0000);
      rot_cmd_fwd_i <= 1'b0; pulse(3); flt(16'h00d6);
   endtask : t_cmd
   task automatic t_lim;
      user_pos_i <= 32'd50; wb(1'b1, 8'h00, 32'h0); cond(NEG, 16'h0000);
      wb(1'b1, 8'h00, 32'h1); cond(NEG, 16'h00cf); cond(32'd5, 16'h0000);
      wb(1'b1, 8'h08, 32'd200); user_pos_i <= 32'd300; cond(32'd5, 16'h00cf);
      cond(NEG, 16'h0000);
      user_pos_i <= 32'd150; wb(1'b1, 8'h00, 32'h2); rev_limit_i <= 1'b1;
      cond(32'd5, 16'h0000); cond(NEG, 16'h00d0);
      rev_limit_i <= 1'b0; fwd_limit_i <= 1'b1; cond(32'd5, 16'h00d0);
      wb(1'b1, 8'h00, 32'h0); cond(32'd5, 16'h0000); fwd_limit_i <= 1'b0;
   endtask : t_lim
   task automatic t_ovl;
      wb(1'b1, 8'h18, 32'd4); current_pct_i <= 16'd101; repeat (2) @(posedge clk_i);
      current_pct_i <= 16'd100; flt(16'h0000);
      current_pct_i <= 16'd101; repeat (8) @(posedge clk_i);
      current_pct_i <= 16'd0; flt(16'h00ce);
   endtask : t_ovl
   task automatic t_cl;
      wb(1'b1, 8'h0c, 32'd10); wb(1'b1, 8'h00, 32'h4); slip <= 32'd5; flt(16'h0000);
      slip <= 32'd20; repeat (3) @(posedge clk_i); slip <= 32'd0; flt(16'h00d5);
      step <= 32'd8; repeat (20) @(posedge clk_i); flt(16'h0000);
      wb(1'b1, 8'h00, 32'h0c); repeat (3) @(posedge clk_i);
      wb(1'b1, 8'h00, 32'h0); flt(16'h00d5);
   endtask : t_cl
   task automatic t_idx;
      step <= 32'd16; repeat (40) @(posedge clk_i); pulse(4);
      repeat (40) @(posedge clk_i); flt(16'h0000);
      step <= 32'd32; repeat (20) @(posedge clk_i); pulse(4);
      repeat (20) @(posedge clk_i); flt(16'h00d8);
   endtask : t_idx
   task automatic final_report;
      if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : final_report
   initial begin
      repeat (20000) @(posedge clk_i);
      n_mismatch++;
      final_report();
   end
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs(); t_cmd(); t_lim(); t_ovl(); t_cl(); t_idx();
      final_report();
   end
endmodule : servo_motion_fault_monitor_tb
